// [dv/pag_pin_model.sv]
/* Board pin model: resolves each pin from the port drive and a board level.
   Assumes the board always drives a pin the port releases. */
`timescale 1ns/10ps
module pag_pin_model
#(parameter int unsigned PIN_COUNT = 24)
(
    // Port drive and board level
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe_n_out,
    input wire logic [PIN_COUNT-1:0] ext_level_in,
    // Resolved level
    output logic [PIN_COUNT-1:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_n_out) | (ext_level_in & pin_oe_n_out);
endmodule

// [dv/pag_port_a_checker.sv]
/* Port A data checker: bus answer and pin relations.
   Assumes it sees only the top module's ports. */
`timescale 1ns/10ps
module pag_port_a_checker
#(parameter int unsigned PIN_COUNT = 24)
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // Bus
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Function side
    input wire logic [PIN_COUNT-1:0] func_sel_in,
    input wire logic [PIN_COUNT-1:0] func_out_in,
    input wire logic [PIN_COUNT-1:0] func_oe_n_in,
    input wire logic [PIN_COUNT-1:0] func_level_out,
    // Pins
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe_n_out
);
    import pag_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic wr_q;
    wire take = ce_in && hsel_in && htrans_in[1] && hready_in;
    wire rd_take = take && !hwrite_in;
    // Write data phase: the store lands at the end of it
    always_ff @(posedge clk_in)
    begin
        wr_q <= rstn_in && take && hwrite_in;
    end
    property p_ready; hreadyout_out && !hresp_out; endproperty
    a_ready: assert property (p_ready) else $error("bus answer not zero-wait okay");
    property p_rd_idle; ce_in && !rd_take |=> hrdata_out == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    property p_upper; rd_take && haddr_in == PAG_UPPER_ADDR |=> hrdata_out[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper high bits not zero");
    property p_lower; rd_take && haddr_in == PAG_LOWER_ADDR |=> hrdata_out[31:16] == 16'h0;
    endproperty
    a_lower: assert property (p_lower) else $error("lower read wider than 16 bits");
    property p_level; ce_in |=> (func_level_out | $past(func_sel_in)) == '1; endproperty
    a_level: assert property (p_level) else $error("level low on port-owned pin");
    property p_rst; $rose(rstn_in) |-> pin_oe_n_out == '1 && pin_out == '0; endproperty
    a_rst: assert property (p_rst) else $error("pins not released by reset");
    // Without a store, and with no pin given to a function this cycle or the last, the pins must hold
    property p_hold;
        ce_in && !wr_q && func_sel_in == '0 && $past(func_sel_in) == '0
        |=> $stable(pin_out) && $stable(pin_oe_n_out);
    endproperty
    a_hold: assert property (p_hold) else $error("pins moved without a store");
    property p_func;
        wr_q && $stable(func_sel_in) && $stable(func_out_in) && $stable(func_oe_n_in)
        |=> ((pin_out ^ $past(pin_out)) & func_sel_in) == '0;
    endproperty
    a_func: assert property (p_func) else $error("store reached a function pin");
    c_wr: cover property (take && hwrite_in);
    c_rd: cover property (rd_take);
    c_func: cover property (wr_q && func_sel_in != '0);
endmodule
bind pag_port_a_data pag_port_a_checker #(.PIN_COUNT(PIN_COUNT)) chk_inst (.*);

// [dv/port_a_data_gpio_test.sv]
/* Port A data bench: AHB-Lite master, board pin model, one task a scenario.
   Assumes a zero-wait slave and the large package. */
`timescale 1ns/10ps
module port_a_data_gpio_test;
    import pag_pkg::*;
    localparam int unsigned PIN_COUNT = 24;
    logic clk_in = 0, rstn_in = 0, ce_in = 1, hsel_in = 0, hwrite_in = 0;
    logic [31:0] haddr_in = 0, hwdata_in = 0, rd;
    logic [1:0] htrans_in = 0;
    logic [2:0] hsize_in = PAG_HSIZE_WORD;
    logic [PIN_COUNT-1:0] func_sel_in = 0, func_out_in = 0, func_oe_n_in = '1;
    logic [PIN_COUNT-1:0] ext_level_in = 0;
    wire [31:0] hrdata_out;
    wire hreadyout_out, hresp_out;
    wire hready_in = hreadyout_out;
    wire [PIN_COUNT-1:0] func_level_out, pin_in, pin_out, pin_oe_n_out;
    int bad_count = 0, n_compared = 0;
    pag_port_a_data #(.PIN_COUNT(PIN_COUNT)) pag_port_a_data_inst (.*);
    pag_pin_model #(.PIN_COUNT(PIN_COUNT)) pag_pin_model_inst (.*);
    initial forever #20 clk_in = ~clk_in;
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [31:0] a, d);
        @(posedge clk_in);
        hsel_in <= 1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        hsel_in <= 0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    // Stored values read back as outputs, so pins and functions cannot mask them
    task automatic t_reset;
        check("oe_n", 32'hFFFFFF, pin_oe_n_out);
        bus(0, PAG_DIR_ADDR, 0);
        check("dir", 0, rd);
        bus(1, PAG_DIR_ADDR, 32'hFFFFFF);
        bus(0, PAG_UPPER_ADDR, 0);
        check("upper", 0, rd);
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 0, rd);
        bus(1, 32'h10, 32'hFFFF);
        bus(0, 32'h10, 0);
        check("unmapped", 0, rd);
        bus(1, PAG_DIR_ADDR, 0);
    endtask
    task automatic t_out;
        bus(1, PAG_DIR_ADDR, 32'hFFFFFF);
        bus(1, PAG_LOWER_ADDR, 32'hA5C3);
        bus(1, PAG_UPPER_ADDR, 32'hFF5A);
        bus(0, PAG_UPPER_ADDR, 0);
        check("upper", 32'h5A, rd);
        check("pins", 32'h5AA5C3, pin_out);
        check("oe_n", 0, pin_oe_n_out);
    endtask
    task automatic t_in;
        bus(1, PAG_DIR_ADDR, 0);
        ext_level_in <= 24'h3C1234;
        bus(1, PAG_LOWER_ADDR, 32'hFFFF);
        check("oe_n", 32'hFFFFFF, pin_oe_n_out);
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 32'h1234, rd);
        bus(0, PAG_UPPER_ADDR, 0);
        check("upper", 32'h3C, rd);
        bus(1, PAG_DIR_ADDR, 32'hFFFFFF);
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 32'hFFFF, rd);
        check("pins", 32'h5AFFFF, pin_out);
    endtask
    // Clock enable low stands in for sleep: a write then is lost, data kept
    task automatic t_sleep;
        ce_in <= 0;
        bus(1, PAG_LOWER_ADDR, 0);
        tick(2);
        check("pins", 32'h5AFFFF, pin_out);
        ce_in <= 1;
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 32'hFFFF, rd);
    endtask
    task automatic t_func;
        bus(1, PAG_DIR_ADDR, 0);
        ext_level_in <= 0;
        tick(3);
        check("level", 32'hFFFFFF, func_level_out);
        func_sel_in <= 24'h0000F0;
        tick(4);
        check("level", 32'hFFFF0F, func_level_out);
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 0, rd);
        func_out_in <= 24'h0000A0;
        func_oe_n_in <= 0;
        bus(1, PAG_DIR_ADDR, 32'hFFFFFF);
        bus(1, PAG_LOWER_ADDR, 32'h0050);
        bus(0, PAG_LOWER_ADDR, 0);
        check("lower", 32'h0050, rd);
        check("pins", 32'h5A00A0, pin_out);
    endtask
    // Second reset in mid-run, pins driven beforehand
    task automatic t_rst;
        rstn_in <= 0;
        tick(2);
        rstn_in <= 1;
        t_reset;
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        tick(16);
        rstn_in <= 1;
        t_reset;
        t_out;
        t_in;
        t_sleep;
        t_func;
        t_rst;
        stop_test;
    end
    initial
    begin
        tick(3000);
        bad_count++;
        stop_test;
    end
endmodule

// [verilog/pag_pkg.sv]
/*
 Constants for the port A data block: register addresses, field widths,
 reset values and AHB-Lite encodings. Assumes a 32-bit AHB-Lite bus.
*/
package pag_pkg;
    localparam int unsigned PAG_PIN_MAX = 24;
    localparam int unsigned PAG_PIN_SMALL = 16;
    localparam int unsigned PAG_UPPER_W = 8;
    localparam int unsigned PAG_LOWER_W = 16;
    // Printed offsets are register indices; byte address is four times them
    localparam logic [31:0] PAG_UPPER_IDX = 32'hFFFF8380;
    localparam logic [31:0] PAG_LOWER_IDX = 32'hFFFF8382;
    localparam logic [31:0] PAG_UPPER_ADDR = {PAG_UPPER_IDX[29:0], 2'h0};
    localparam logic [31:0] PAG_LOWER_ADDR = {PAG_LOWER_IDX[29:0], 2'h0};
    localparam logic [31:0] PAG_DIR_ADDR = 32'hFFFE0E10;
    localparam logic [7:0] PAG_UPPER_RST = 8'h00;
    localparam logic [15:0] PAG_LOWER_RST = 16'h0000;
    localparam logic [23:0] PAG_DIR_RST = 24'h000000;
    localparam logic [2:0] PAG_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] PAG_HSIZE_HALF = 3'h1;
    localparam logic [2:0] PAG_HSIZE_WORD = 3'h2;
    localparam logic PAG_HRESP_OKAY = 1'h0;
endpackage

// [verilog/pag_port_a_data.sv]
/*
 Port A data block: AHB-Lite slave holding the upper and lower pin data
 registers plus a direction register, and the per-pin output mux.
 Assumes the pin function controller supplies per-pin function selects
 and the function's own output and enable; pins arrive asynchronously.
*/
`timescale 1ns/10ps
module pag_port_a_data
#(
    parameter int unsigned PIN_COUNT = pag_pkg::PAG_PIN_MAX
)
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Pin function controller side
    input wire logic [PIN_COUNT-1:0] func_sel_in,
    input wire logic [PIN_COUNT-1:0] func_out_in,
    input wire logic [PIN_COUNT-1:0] func_oe_n_in,
    output logic [PIN_COUNT-1:0] func_level_out,
    // Pins
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_n_out
);
    import pag_pkg::*;

    // Single data register set for the port
    logic [PAG_UPPER_W-1:0] upper_data;
    logic [PAG_LOWER_W-1:0] lower_data;
    logic [PAG_PIN_MAX-1:0] dir_bits;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic ph_write;
    logic ph_sel_upper;
    logic ph_sel_lower;
    logic ph_sel_dir;
    logic [3:0] ph_be;

    // Address phase decode
    wire addr_phase = hsel_in & htrans_in[1] & hready_in;
    wire hit_upper = haddr_in[31:2] == PAG_UPPER_ADDR[31:2];
    wire hit_lower = haddr_in[31:2] == PAG_LOWER_ADDR[31:2];
    wire hit_dir = haddr_in[31:2] == PAG_DIR_ADDR[31:2];
    wire size_byte = hsize_in == PAG_HSIZE_BYTE;
    wire size_half = hsize_in == PAG_HSIZE_HALF;
    wire size_word = hsize_in == PAG_HSIZE_WORD;
    wire [3:0] be_byte = 4'h1 << haddr_in[1:0];
    wire [3:0] be_half = haddr_in[1] ? 4'hC : 4'h3;
    // All three access widths honoured
    wire [3:0] addr_be = size_word ? 4'hF :
                         size_half ? be_half :
                         size_byte ? be_byte : 4'h0;

    // Data phase write enables per byte lane
    wire wr_upper = ph_write & ph_sel_upper;
    wire wr_lower = ph_write & ph_sel_lower;
    wire wr_dir = ph_write & ph_sel_dir;
    wire [15:0] lane_mask = {{8{ph_be[1]}}, {8{ph_be[0]}}};
    wire [23:0] dir_mask = {{8{ph_be[2]}}, lane_mask};

    // Bits 15..8 of the upper word have no storage
    wire [PAG_UPPER_W-1:0] next_upper = wr_upper ?
        (hwdata_in[PAG_UPPER_W-1:0] & lane_mask[PAG_UPPER_W-1:0]) |
        (upper_data & ~lane_mask[PAG_UPPER_W-1:0]) : upper_data;
    // Writes land in storage whatever the pin mode, unless ce_in is low
    wire [PAG_LOWER_W-1:0] next_lower = wr_lower ?
        (hwdata_in[PAG_LOWER_W-1:0] & lane_mask) |
        (lower_data & ~lane_mask) : lower_data;
    wire [PAG_PIN_MAX-1:0] next_dir = wr_dir ?
        (hwdata_in[PAG_PIN_MAX-1:0] & dir_mask) |
        (dir_bits & ~dir_mask) : dir_bits;

    // Full data vector, pin 23 at upper bit 7
    wire [PAG_PIN_MAX-1:0] next_data = {next_upper, next_lower};
    wire [PAG_PIN_MAX-1:0] pin_level;
    wire [PAG_PIN_MAX-1:0] read_view;

    genvar gi;
    generate
        for (gi = 0; gi < PAG_PIN_MAX; gi = gi + 1)
        begin : g_view
            if (gi < PIN_COUNT)
            begin : g_real
                assign pin_level[gi] = pin_sync[gi];
            end
            else
            begin : g_absent
                // Missing pins set as inputs read low in the read view; as outputs they read storage
                assign pin_level[gi] = 1'b0;
            end
            // Output pins read storage, input pins read the pin
            assign read_view[gi] = next_dir[gi] ? next_data[gi] : pin_level[gi];
        end
    endgenerate

    // Read data uses forwarded next values to cover write-then-read
    wire [31:0] rd_upper = {24'h000000, read_view[PAG_PIN_MAX-1:PAG_LOWER_W]};
    wire [31:0] rd_lower = {16'h0000, read_view[PAG_LOWER_W-1:0]};
    wire [31:0] rd_dir = {8'h00, next_dir};
    wire [31:0] rd_word = hit_upper ? rd_upper :
                          hit_lower ? rd_lower :
                          hit_dir ? rd_dir : 32'h00000000;
    wire rd_take = addr_phase & ~hwrite_in;

    // Per-pin drive selection
    logic [PIN_COUNT-1:0] next_pin;
    logic [PIN_COUNT-1:0] next_oe_n;
    logic [PIN_COUNT-1:0] next_func_level;

    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
        begin : g_pin
            // Another function owns the pin: stored data never reaches it
            // Ordinary output drives its data bit, input releases the pin
            assign next_pin[gi] = func_sel_in[gi] ? func_out_in[gi] : next_data[gi];
            assign next_oe_n[gi] = func_sel_in[gi] ? func_oe_n_in[gi] : ~next_dir[gi];
            // Function sees high while the port owns the pin, so a low pin
            // at the switch appears as a falling edge
            assign next_func_level[gi] = func_sel_in[gi] ? pin_sync[gi] : 1'b1;
        end
    endgenerate

    // Pin synchroniser first stage; nothing else reads it
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pin_meta <= '0;
        end
        else if (ce_in)
        begin
            pin_meta <= pin_in;
        end
    end

    // Second stage, the only pin view the logic uses
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pin_sync <= '0;
        end
        else if (ce_in)
        begin
            pin_sync <= pin_meta;
        end
    end

    // Only the power-on reset input clears data; no other reset reaches it
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            upper_data <= PAG_UPPER_RST;
        end
        else if (ce_in)
        begin
            upper_data <= next_upper;
        end
    end

    // Lower data, same reset policy
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            lower_data <= PAG_LOWER_RST;
        end
        else if (ce_in)
        begin
            lower_data <= next_lower;
        end
    end

    // Direction bits start as inputs, so no port-owned pin is driven after reset
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            dir_bits <= PAG_DIR_RST;
        end
        else if (ce_in)
        begin
            dir_bits <= next_dir;
        end
    end

    // Address phase capture: write flag
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ph_write <= 1'b0;
        end
        else if (ce_in)
        begin
            ph_write <= addr_phase & hwrite_in;
        end
    end

    // Register selects, held for the data phase
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ph_sel_upper <= 1'b0;
            ph_sel_lower <= 1'b0;
            ph_sel_dir <= 1'b0;
        end
        else if (ce_in)
        begin
            ph_sel_upper <= hit_upper;
            ph_sel_lower <= hit_lower;
            ph_sel_dir <= hit_dir;
        end
    end

    // Byte lanes of the pending write
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ph_be <= 4'h0;
        end
        else if (ce_in)
        begin
            ph_be <= addr_be;
        end
    end

    // Read data stands for the data phase only, zero otherwise
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            hrdata_out <= 32'h00000000;
        end
        else if (ce_in)
        begin
            hrdata_out <= rd_take ? rd_word : 32'h00000000;
        end
    end

    // Zero wait state slave
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            hreadyout_out <= 1'b1;
        end
        else if (ce_in)
        begin
            hreadyout_out <= 1'b1;
        end
    end

    // Response is always OKAY
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            hresp_out <= PAG_HRESP_OKAY;
        end
        else if (ce_in)
        begin
            hresp_out <= PAG_HRESP_OKAY;
        end
    end

    // Pins start released; function selects from the controller decide
    // the per-mode initial use after reset
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pin_out <= '0;
        end
        else if (ce_in)
        begin
            pin_out <= next_pin;
        end
    end

    // Output enables, low while driving
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pin_oe_n_out <= '1;
        end
        else if (ce_in)
        begin
            pin_oe_n_out <= next_oe_n;
        end
    end

    // Level seen by the other function, high while the port owns the pin
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            func_level_out <= '1;
        end
        else if (ce_in)
        begin
            func_level_out <= next_func_level;
        end
    end
endmodule
